// file: rtl/ext_request_flag.sv
/*
  Request flag of one external interrupt pin, edge or low level.
  Assumes a pin level already synchronised to clk.
*/
`timescale 1ns/100ps
module ext_request_flag import irq_ctrl_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // pin and mode
  input wire logic pin_level,
  input wire logic edge_select,
  // clears and software access
  input wire logic enter_clear,
  input wire logic sw_write,
  input wire logic sw_value,
  // flag out
  output logic flag
);
  logic pin_prev_q;
  logic flag_q;
  logic fall;

  // previous sample for fall detection
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_prev_q <= 1'b1;
    end else begin
      pin_prev_q <= pin_level;
    end
  end

  assign fall = pin_prev_q & ~pin_level;

  // hardware set wins over any clear in the same cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_q <= 1'b0;
    end else if (!edge_select) begin
      flag_q <= ~pin_level;
    end else if (fall) begin
      flag_q <= 1'b1;
    end else if (enter_clear) begin
      flag_q <= 1'b0;
    end else if (sw_write) begin
      flag_q <= sw_value;
    end
  end

  assign flag = flag_q;
endmodule : ext_request_flag

// file: rtl/irq_ctrl_pkg.sv
/*
  Shared constants and types of the two-level interrupt controller:
  register map, field positions, reset values, vectors, level states.
  Assumes nothing; imported whole by every design module.
*/
package irq_ctrl_pkg;
  // --------------------------------------------------------------
  // sources, in polling order, bit position equals source index
  // --------------------------------------------------------------
  localparam int N_SRC = 5;
  localparam int SRC_EXT0 = 0;
  localparam int SRC_TIMER0 = 1;
  localparam int SRC_EXT1 = 2;
  localparam int SRC_TIMER1 = 3;
  localparam int SRC_SERIAL = 4;
  localparam int GLOBAL_EN_BIT = 7;

  // --------------------------------------------------------------
  // register map (index registers sit at four times the index)
  // --------------------------------------------------------------
  localparam logic [7:0] IDX_SOURCE_ENABLE = 8'ha8;
  localparam logic [7:0] IDX_LEVEL_SELECT = 8'ha9;
  localparam logic [11:0] ADDR_SOURCE_ENABLE = {2'h0, IDX_SOURCE_ENABLE, 2'h0};
  localparam logic [11:0] ADDR_LEVEL_SELECT = {2'h0, IDX_LEVEL_SELECT, 2'h0};
  localparam logic [11:0] ADDR_TIMER_CTRL = 12'h000;
  localparam logic [11:0] ADDR_EVENT_STATUS = 12'h004;
  localparam logic [11:0] ADDR_EVENT_MASK = 12'h008;
  localparam logic [11:0] ADDR_LEVEL_STATE = 12'h00c;

  // timer_ctrl_reg field positions
  localparam int TC_EXT0_EDGE = 0;
  localparam int TC_EXT0_FLAG = 1;
  localparam int TC_EXT1_EDGE = 2;
  localparam int TC_EXT1_FLAG = 3;
  localparam int TC_TIMER0_FLAG = 5;
  localparam int TC_TIMER1_FLAG = 7;

  // reset values
  localparam logic [7:0] RST_SOURCE_ENABLE = 8'h00;
  localparam logic [7:0] RST_LEVEL_SELECT = 8'h00;
  localparam logic [7:0] RST_TIMER_CTRL = 8'h00;
  localparam logic [4:0] RST_EVENT_MASK = 5'h00;

  // stack advance on a hardware call, in bytes
  localparam logic [7:0] SP_STEP = 8'h02;

  // entry addresses, index = source
  localparam logic [N_SRC-1:0][7:0] VECTORS = {8'h23, 8'h1b, 8'h13, 8'h0b, 8'h03};

  // --------------------------------------------------------------
  // types
  // --------------------------------------------------------------
  typedef enum logic [1:0] {
    LVL_IDLE = 2'b00,
    LVL_LOW = 2'b01,
    LVL_HIGH = 2'b10,
    LVL_NESTED = 2'b11
  } level_state_e;

  typedef struct packed {
    logic [7:0] vector;
    logic high;
    logic [2:0] source;
  } grant_s;

  typedef struct packed {
    logic [15:0] ret_pc;
    logic [7:0] sp;
    logic [7:0] target;
  } call_s;
endpackage : irq_ctrl_pkg

// file: rtl/pin_sync.sv
/*
  Multi-bit level synchroniser for asynchronous pins.
  Assumes each bit is an independent level; no word coherence.
*/
`timescale 1ns/100ps
module pin_sync import irq_ctrl_pkg::*; #(
  parameter int WIDTH = 2,
  parameter int STAGES = 2
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // pins in, synchronised levels out
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  // fewer than two stages would not settle metastability
  if (STAGES < 2) begin : g_check
    $error("pin_sync needs at least two stages");
  end

  logic [STAGES-1:0][WIDTH-1:0] chain_q;

  // first stage is read only by the next stage; reset to the idle high
  // level of active-low pins, so no false fall follows reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      chain_q <= '1;
    end else begin
      chain_q <= {chain_q[STAGES-2:0], async_in};
    end
  end

  assign sync_out = chain_q[STAGES-1];
endmodule : pin_sync

// file: rtl/two_level_interrupt_control.sv
/*
  Two-level nested interrupt controller with APB register access.
  Five sources: two external pins, two timer overflows, serial port.
  Assumes the core sequencer runs on pclk, pulses irq_take when it
  enters a routine and return_from_irq_instr when it retires a return.
*/
// Our own choice: the APB register port.
// Function
// - global enable gates every acknowledge
// - per-source enable, zero blocks acknowledge
// - per-source priority bit, one is high
// - high request preempts running low routine
// - same or higher running level blocks request
// - simultaneous: high level wins
// - equal level: fixed polling order
// - polling order only breaks ties
// - nested call pushes pc, sp plus two
// - return clears high active, resumes low
// - low active stays set after nested return
// - edge select one: falling edge, else level
// - edge flag set on high then low
// - edge flag cleared on routine entry
// - level flag follows sampled pin
// - each source has own entry address
`timescale 1ns/100ps
module two_level_interrupt_control import irq_ctrl_pkg::*; (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // external request pins, asynchronous
  input wire logic ext_irq_pin_a,
  input wire logic ext_irq_pin_b,
  // on-chip peripherals, same clock
  input wire logic timer0_overflow_set,
  input wire logic timer1_overflow_set,
  input wire logic serial_rx_tx_flags,
  // core sequencer
  output logic irq_req,
  output grant_s irq_grant,
  input wire logic irq_take,
  input wire logic return_from_irq_instr,
  input wire logic [15:0] core_pc,
  input wire logic [7:0] core_sp,
  output logic call_valid,
  output call_s call,
  // event interrupt
  output logic irq_out
);
  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [7:0] source_enable_q;
  logic [7:0] level_select_q;
  logic [1:0] edge_select_q;
  logic timer0_flag_q;
  logic timer1_flag_q;
  logic [N_SRC-1:0] status_q;
  logic [N_SRC-1:0] mask_q;
  level_state_e level_q;
  level_state_e level_d;
  logic irq_req_q;
  grant_s grant_q;
  grant_s grant_d;
  logic grant_ok;
  logic call_valid_q;
  call_s call_q;
  logic [31:0] prdata_q;
  logic pslverr_q;

  logic [1:0] pins_sync;
  logic ext0_flag;
  logic ext1_flag;
  logic [N_SRC-1:0] flags;
  logic [N_SRC-1:0] flags_prev_q;
  logic [N_SRC-1:0] enabled;
  logic [N_SRC-1:0] high_req;
  logic [N_SRC-1:0] low_req;
  logic high_open;
  logic low_open;
  logic take;
  logic [N_SRC-1:0] enter_clear;

  logic wr_en;
  logic rd_en;
  logic hit;
  logic wr_timer_ctrl;
  logic [7:0] timer_ctrl_view;
  logic [1:0] level_view;

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  // every access completes in its first access cycle
  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & penable & ~pwrite;
  assign wr_timer_ctrl = wr_en & (paddr == ADDR_TIMER_CTRL);

  // address decode
  always_comb begin
    if (paddr == ADDR_SOURCE_ENABLE) begin
      hit = 1'b1;
    end else if (paddr == ADDR_LEVEL_SELECT) begin
      hit = 1'b1;
    end else if (paddr == ADDR_TIMER_CTRL) begin
      hit = 1'b1;
    end else if (paddr == ADDR_EVENT_STATUS) begin
      hit = 1'b1;
    end else if (paddr == ADDR_EVENT_MASK) begin
      hit = 1'b1;
    end else if (paddr == ADDR_LEVEL_STATE) begin
      hit = 1'b1;
    end else begin
      hit = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  // enable and level registers; the reserved bits read zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      source_enable_q <= RST_SOURCE_ENABLE;
      level_select_q <= RST_LEVEL_SELECT;
    end else if (wr_en && paddr == ADDR_SOURCE_ENABLE) begin
      source_enable_q <= {pwdata[GLOBAL_EN_BIT], 2'b00, pwdata[N_SRC-1:0]};
    end else if (wr_en && paddr == ADDR_LEVEL_SELECT) begin
      level_select_q <= {3'b000, pwdata[N_SRC-1:0]};
    end
  end

  // edge selects of the two pins, event mask
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      edge_select_q <= {RST_TIMER_CTRL[TC_EXT1_EDGE], RST_TIMER_CTRL[TC_EXT0_EDGE]};
      mask_q <= RST_EVENT_MASK;
    end else if (wr_timer_ctrl) begin
      edge_select_q <= {pwdata[TC_EXT1_EDGE], pwdata[TC_EXT0_EDGE]};
    end else if (wr_en && paddr == ADDR_EVENT_MASK) begin
      mask_q <= pwdata[N_SRC-1:0];
    end
  end

  // ----------------------------------------------------------------
  // request flags
  // ----------------------------------------------------------------
  pin_sync #(
    .WIDTH(2),
    .STAGES(2)
  ) u_pin_sync (
    .clk(pclk),
    .rst_n(presetn),
    .async_in({ext_irq_pin_b, ext_irq_pin_a}),
    .sync_out(pins_sync)
  );

  ext_request_flag u_ext0_flag (
    .clk(pclk),
    .rst_n(presetn),
    .pin_level(pins_sync[0]),
    .edge_select(edge_select_q[0]),
    .enter_clear(enter_clear[SRC_EXT0]),
    .sw_write(wr_timer_ctrl),
    .sw_value(pwdata[TC_EXT0_FLAG]),
    .flag(ext0_flag)
  );

  ext_request_flag u_ext1_flag (
    .clk(pclk),
    .rst_n(presetn),
    .pin_level(pins_sync[1]),
    .edge_select(edge_select_q[1]),
    .enter_clear(enter_clear[SRC_EXT1]),
    .sw_write(wr_timer_ctrl),
    .sw_value(pwdata[TC_EXT1_FLAG]),
    .flag(ext1_flag)
  );

  // timer overflow flags: set wins over entry clear and software clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer0_flag_q <= RST_TIMER_CTRL[TC_TIMER0_FLAG];
      timer1_flag_q <= RST_TIMER_CTRL[TC_TIMER1_FLAG];
    end else begin
      if (timer0_overflow_set) begin
        timer0_flag_q <= 1'b1;
      end else if (enter_clear[SRC_TIMER0]) begin
        timer0_flag_q <= 1'b0;
      end else if (wr_timer_ctrl) begin
        timer0_flag_q <= pwdata[TC_TIMER0_FLAG];
      end
      if (timer1_overflow_set) begin
        timer1_flag_q <= 1'b1;
      end else if (enter_clear[SRC_TIMER1]) begin
        timer1_flag_q <= 1'b0;
      end else if (wr_timer_ctrl) begin
        timer1_flag_q <= pwdata[TC_TIMER1_FLAG];
      end
    end
  end

  // bit order is the polling order; serial flag is cleared by its routine
  assign flags = {serial_rx_tx_flags, timer1_flag_q, ext1_flag, timer0_flag_q, ext0_flag};

  // ----------------------------------------------------------------
  // arbitration
  // ----------------------------------------------------------------
  assign enabled = flags & source_enable_q[N_SRC-1:0]
                 & {N_SRC{source_enable_q[GLOBAL_EN_BIT]}};
  assign high_req = enabled & level_select_q[N_SRC-1:0];
  assign low_req = enabled & ~level_select_q[N_SRC-1:0];
  // a running high routine blocks everything, a low one only low
  assign high_open = (level_q == LVL_IDLE) || (level_q == LVL_LOW);
  assign low_open = (level_q == LVL_IDLE);

  // high level first, then lowest index; order never reopens a level
  always_comb begin
    grant_d = '0;
    grant_ok = 1'b0;
    if (high_open && |high_req) begin
      grant_ok = 1'b1;
      grant_d.high = 1'b1;
      for (int i = N_SRC - 1; i >= 0; i--) begin
        if (high_req[i]) begin
          grant_d.source = 3'(i);
        end
      end
    end else if (low_open && |low_req) begin
      grant_ok = 1'b1;
      for (int i = N_SRC - 1; i >= 0; i--) begin
        if (low_req[i]) begin
          grant_d.source = 3'(i);
        end
      end
    end
    grant_d.vector = VECTORS[grant_d.source];
  end

  // the offer is registered so vector and level are flop outputs;
  // it lags the flags by one cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_req_q <= 1'b0;
      grant_q <= '0;
    end else if (take) begin
      irq_req_q <= 1'b0; // withdrawn while the taken flag clears
      grant_q <= grant_q;
    end else begin
      irq_req_q <= grant_ok;
      grant_q <= grant_d;
    end
  end

  assign take = irq_take & irq_req_q;

  // entry clears timers and edge-mode pins, never the serial flag
  always_comb begin
    enter_clear = '0;
    if (take && grant_q.source != 3'(SRC_SERIAL)) begin
      enter_clear[grant_q.source] = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // active level flip-flops
  // ----------------------------------------------------------------
  always_comb begin
    level_d = level_q;
    case (level_q)
      LVL_IDLE: begin
        if (take) begin
          level_d = grant_q.high ? LVL_HIGH : LVL_LOW;
        end
      end
      LVL_LOW: begin
        if (take && grant_q.high) begin
          level_d = LVL_NESTED;
        end else if (return_from_irq_instr) begin
          level_d = LVL_IDLE;
        end
      end
      LVL_HIGH: begin
        if (return_from_irq_instr) begin
          level_d = LVL_IDLE;
        end
      end
      LVL_NESTED: begin
        if (return_from_irq_instr) begin
          level_d = LVL_LOW;
        end
      end
      default: begin
        level_d = LVL_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_q <= LVL_IDLE;
    end else begin
      level_q <= level_d;
    end
  end

  // ----------------------------------------------------------------
  // hardware call to the core
  // ----------------------------------------------------------------
  // one-cycle call: return address, stack after two pushes, target
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      call_valid_q <= 1'b0;
      call_q <= '0;
    end else begin
      call_valid_q <= take;
      if (take) begin
        call_q.ret_pc <= core_pc;
        call_q.sp <= 8'(core_sp + SP_STEP);
        call_q.target <= grant_q.vector;
      end
    end
  end

  // ----------------------------------------------------------------
  // event status and interrupt
  // ----------------------------------------------------------------
  // a rising request flag is an event; a read clears only the bits it
  // returned, so an event latched in the setup cycle is not lost
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_prev_q <= '0;
      status_q <= '0;
    end else begin
      flags_prev_q <= flags;
      if (rd_en && paddr == ADDR_EVENT_STATUS) begin
        status_q <= (status_q & ~prdata_q[N_SRC-1:0]) | (flags & ~flags_prev_q);
      end else begin
        status_q <= status_q | (flags & ~flags_prev_q);
      end
    end
  end

  assign irq_out = |(status_q & mask_q);

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  assign timer_ctrl_view = {timer1_flag_q, 1'b0, timer0_flag_q, 1'b0,
                            ext1_flag, edge_select_q[1], ext0_flag, edge_select_q[0]};
  assign level_view = level_q;

  // read data registered at the edge that ends the setup cycle, holds until next read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= '0;
      pslverr_q <= 1'b0;
    end else if (psel && !penable) begin
      pslverr_q <= ~hit;
      if (pwrite) begin
        prdata_q <= prdata_q;
      end else if (paddr == ADDR_SOURCE_ENABLE) begin
        prdata_q <= {24'h0, source_enable_q};
      end else if (paddr == ADDR_LEVEL_SELECT) begin
        prdata_q <= {24'h0, level_select_q};
      end else if (paddr == ADDR_TIMER_CTRL) begin
        prdata_q <= {24'h0, timer_ctrl_view};
      end else if (paddr == ADDR_EVENT_STATUS) begin
        prdata_q <= {27'h0, status_q};
      end else if (paddr == ADDR_EVENT_MASK) begin
        prdata_q <= {27'h0, mask_q};
      end else if (paddr == ADDR_LEVEL_STATE) begin
        prdata_q <= {29'h0, serial_rx_tx_flags, level_view};
      end else begin
        prdata_q <= '0;
      end
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign prdata = prdata_q;
  assign pready = 1'b1;
  assign pslverr = pslverr_q & psel & penable;
  assign irq_req = irq_req_q;
  assign irq_grant = grant_q;
  assign call_valid = call_valid_q;
  assign call = call_q;
endmodule : two_level_interrupt_control

// file: sim/core_seq_model.sv
/*
  Behavioural core sequencer: enters routines, keeps a running pc
  and a stack pointer, retires returns when told.
  Assumes the bench calls take_now only while an offer stands.
*/
`timescale 1ns/100ps
module core_seq_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // offer from the controller
  input wire logic irq_req,
  // sequencer outputs
  output logic irq_take,
  output logic return_from_irq_instr,
  output logic [15:0] core_pc,
  output logic [7:0] core_sp
);
  // pc moves every cycle, so a stale sample shows in the frame
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) core_pc <= 16'h0100;
    else core_pc <= core_pc + 16'h0001;
  end
  // quiet outputs from time zero
  initial begin
    irq_take = 1'b0;
    return_from_irq_instr = 1'b0;
    core_sp = 8'h07;
  end
  // entry after slow cycles of latency, only on a standing offer
  task take_now(input int slow);
    repeat (slow) @(posedge pclk);
    @(posedge pclk);
    irq_take <= irq_req;
    @(posedge pclk);
    irq_take <= 1'b0;
    core_sp <= core_sp + 8'h02;
  endtask : take_now
  // every routine ends with a return pulse
  task ret_now();
    @(posedge pclk);
    return_from_irq_instr <= 1'b1;
    @(posedge pclk);
    return_from_irq_instr <= 1'b0;
    core_sp <= core_sp - 8'h02;
  endtask : ret_now
endmodule : core_seq_model

// file: sim/irq_ctrl_assertions.sv
/*
  Checker of the controller ports: core handshake, call frame,
  offers against active levels, apb answers.
  Assumes it is bound onto the top module; presetn is the reset.
*/
`timescale 1ns/100ps
module irq_ctrl_checker import irq_ctrl_pkg::*; (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // core side
  input wire logic irq_req,
  input wire grant_s irq_grant,
  input wire logic irq_take,
  input wire logic return_from_irq_instr,
  input wire logic [15:0] core_pc,
  input wire logic [7:0] core_sp,
  input wire logic call_valid,
  input wire call_s call
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // --------------------------------------------------------------
  // active levels seen from the core pulses
  // --------------------------------------------------------------
  logic lo_q;
  logic hi_q;
  // a return leaves the higher active level first
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lo_q <= 1'b0;
      hi_q <= 1'b0;
    end else if (irq_take && irq_req) begin
      if (irq_grant.high) hi_q <= 1'b1;
      else lo_q <= 1'b1;
    end else if (return_from_irq_instr) begin
      if (hi_q) hi_q <= 1'b0;
      else lo_q <= 1'b0;
    end
  end
  // --------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------
  a_take_calls: assert property (irq_take && irq_req |=> call_valid && !irq_req)
    else $error("take not answered by a call");
  a_call_cause: assert property (call_valid |-> $past(irq_take) && $past(irq_req))
    else $error("call without a take");
  a_sp_step: assert property (call_valid |-> call.sp == $past(core_sp) + 8'h02)
    else $error("stack pointer not advanced by two");
  a_ret_pc: assert property (call_valid |-> call.ret_pc == $past(core_pc))
    else $error("wrong return address pushed");
  a_call_target: assert property (call_valid |-> call.target == $past(irq_grant.vector))
    else $error("call target differs from offer");
  a_vector_map: assert property (irq_req |-> irq_grant.vector == {2'h0, irq_grant.source, 3'h3})
    else $error("vector does not match source");
  a_high_blocks: assert property (hi_q |-> !irq_req)
    else $error("offer during a high routine");
  a_low_admits: assert property (lo_q && irq_req |-> irq_grant.high)
    else $error("low offer during a low routine");
  a_err_access: assert property (pslverr |-> psel && penable)
    else $error("error outside an access cycle");
  a_zero_wait: assert property (psel && penable |-> pready)
    else $error("access cycle not ready");
endmodule : irq_ctrl_checker

bind two_level_interrupt_control irq_ctrl_checker irq_ctrl_checker_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .irq_req(irq_req),
  .irq_grant(irq_grant), .irq_take(irq_take),
  .return_from_irq_instr(return_from_irq_instr), .core_pc(core_pc),
  .core_sp(core_sp), .call_valid(call_valid), .call(call)
);

// file: sim/two_level_interrupt_control_bench.sv
/*
  Bench of the controller: apb tasks, pin and peripheral stimulus,
  a core model serving the offers.
  Assumes the package, design, checker and core model come first.
*/
`timescale 1ns/100ps
module two_level_interrupt_control_bench import irq_ctrl_pkg::*;;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic pin_a, pin_b, t0, t1, ser, irq_req, irq_take, ret;
  logic call_valid, irq_out;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] core_pc;
  logic [7:0] core_sp;
  grant_s irq_grant;
  call_s call;
  int n_mismatch = 0;
  int n_checks = 0;
  int cyc = 0;
  // --------------------------------------------------------------
  // units
  // --------------------------------------------------------------
  two_level_interrupt_control two_level_interrupt_control_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ext_irq_pin_a(pin_a),
    .ext_irq_pin_b(pin_b), .timer0_overflow_set(t0),
    .timer1_overflow_set(t1), .serial_rx_tx_flags(ser),
    .irq_req(irq_req), .irq_grant(irq_grant), .irq_take(irq_take),
    .return_from_irq_instr(ret), .core_pc(core_pc), .core_sp(core_sp),
    .call_valid(call_valid), .call(call), .irq_out(irq_out));
  core_seq_model core_seq_model_inst (
    .pclk(pclk), .presetn(presetn), .irq_req(irq_req),
    .irq_take(irq_take), .return_from_irq_instr(ret),
    .core_pc(core_pc), .core_sp(core_sp));
  // --------------------------------------------------------------
  // tasks
  // --------------------------------------------------------------
  task test_done();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : test_done
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask : chk
  // one apb transfer; answer taken at the edge with pready high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task rdc(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask : rdc
  task idle(input int n);
    repeat (n) @(posedge pclk);
  endtask : idle
  task pulse(input logic a, input logic b);
    @(posedge pclk);
    t0 <= a;
    t1 <= b;
    @(posedge pclk);
    t0 <= 1'b0;
    t1 <= 1'b0;
  endtask : pulse
  task no_req(input int n);
    repeat (n) begin
      @(posedge pclk);
      #1;
      chk(irq_req, 1'b0);
    end
  endtask : no_req
  // wait for an offer, check it, let the core enter
  task serve(input int src, input logic hi);
    int k;
    k = 0;
    @(posedge pclk);
    #1;
    while (irq_req !== 1'b1 && k < 20) begin
      @(posedge pclk);
      #1;
      k++;
    end
    chk(irq_req, 1'b1);
    chk({irq_grant.source, irq_grant.high}, {src[2:0], hi});
    chk(irq_grant.vector, 8'h03 + 8'h08 * src[7:0]);
    core_seq_model_inst.take_now(src % 2);
  endtask : serve
  // --------------------------------------------------------------
  // clock, timeout, sequence
  // --------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  // a hang ends the run as a mismatch
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      $display("[FAIL] %0t timeout", $time);
      test_done();
    end
  end
  initial begin
    {psel, penable, pwrite, t0, t1, ser, paddr, pwdata} = '0;
    {presetn, pin_a, pin_b} = 3'b011;
    idle(10);
    presetn <= 1'b1;
    // reset values, reserved bits, unmapped place
    rdc(ADDR_SOURCE_ENABLE, 32'h0);
    rdc(ADDR_LEVEL_SELECT, 32'h0);
    rdc(ADDR_TIMER_CTRL, 32'h0);
    wr(ADDR_SOURCE_ENABLE, 32'hff);
    rdc(ADDR_SOURCE_ENABLE, 32'h9f);
    apb(1'b0, 12'h010, 32'h0);
    chk(err, 1'b1);
    chk(rd, 32'h0);
    // falling edge on pin a, gated by the enables
    wr(ADDR_SOURCE_ENABLE, 32'h1f);
    wr(ADDR_TIMER_CTRL, 32'h01);
    pin_a <= 1'b0;
    idle(4);
    pin_a <= 1'b1;
    idle(4);
    rdc(ADDR_TIMER_CTRL, 32'h03);
    no_req(6);
    wr(ADDR_SOURCE_ENABLE, 32'h9e);
    no_req(6);
    wr(ADDR_SOURCE_ENABLE, 32'h9f);
    serve(0, 1'b0);
    rdc(ADDR_TIMER_CTRL, 32'h01);
    core_seq_model_inst.ret_now();
    // four low requests at once, level mode on pin b
    pin_b <= 1'b0;
    ser <= 1'b1;
    pulse(1'b1, 1'b1);
    idle(3);
    serve(1, 1'b0);
    no_req(6);
    core_seq_model_inst.ret_now();
    serve(2, 1'b0);
    pin_b <= 1'b1;
    idle(4);
    rdc(ADDR_TIMER_CTRL, 32'h81);
    core_seq_model_inst.ret_now();
    serve(3, 1'b0);
    core_seq_model_inst.ret_now();
    serve(4, 1'b0);
    ser <= 1'b0;
    core_seq_model_inst.ret_now();
    // timer 1 high: nesting and return
    wr(ADDR_LEVEL_SELECT, 32'h08);
    pulse(1'b1, 1'b0);
    serve(1, 1'b0);
    pulse(1'b0, 1'b1);
    serve(3, 1'b1);
    rdc(ADDR_LEVEL_STATE, 32'h03);
    pulse(1'b1, 1'b1);
    no_req(6);
    core_seq_model_inst.ret_now();
    serve(3, 1'b1);
    core_seq_model_inst.ret_now();
    no_req(6);
    core_seq_model_inst.ret_now();
    serve(1, 1'b0);
    core_seq_model_inst.ret_now();
    pulse(1'b1, 1'b1);
    serve(3, 1'b1);
    core_seq_model_inst.ret_now();
    serve(1, 1'b0);
    core_seq_model_inst.ret_now();
    // event status, mask, read clear, interrupt line
    wr(ADDR_SOURCE_ENABLE, 32'h00);
    wr(ADDR_EVENT_MASK, 32'h00);
    apb(1'b0, ADDR_EVENT_STATUS, 32'h0);
    pulse(1'b1, 1'b0);
    idle(2);
    chk(irq_out, 1'b0);
    wr(ADDR_EVENT_MASK, 32'h02);
    idle(2);
    chk(irq_out, 1'b1);
    rdc(ADDR_EVENT_STATUS, 32'h02);
    idle(2);
    chk(irq_out, 1'b0);
    test_done();
  end
endmodule : two_level_interrupt_control_bench
